//--- src/axd_axis.sv
// What this block does
// - write busy output held low at most 2 cycles after write strobe rises.
// - axis outputs change only on rising clock edges, all from flip-flops.
// - quadrature input changes reach real position counter within 4 cycles.
// - count up or down rising edges reach real position counter within 4 cycles.
// - first drive pulse appears 3 cycles after write busy rises.
// - direction output valid 1 cycle after write busy rises.
// - drive active rises together with write busy after a drive command.
// - accel and decel phases valid 3 cycles after busy rises, low after last pulse.
// - 32-bit data: bits 15..0 in data low word, 31..16 in data high word.
`timescale 1ns/100ps
`default_nettype none
`include "axd_map.svh"

module axd_axis
    import axd_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic write_strobe_n_in,
    input wire logic [2:0] addr_in,
    input wire logic [15:0] data_in,
    input wire logic byte_bus_in,
    input wire logic pulse_dir_mode_in,
    input wire logic count_mode_in,
    input wire logic encoder_phase_a_in,
    input wire logic encoder_phase_b_in,
    input wire logic count_up_input_in,
    input wire logic count_down_input_in,
    output logic write_busy_n_out,
    output logic plus_pulse_out,
    output logic minus_pulse_out,
    output logic single_pulse_out,
    output logic direction_out,
    output logic drive_active_out,
    output logic accel_phase_out,
    output logic decel_phase_out,
    output logic [31:0] real_pos_out
);
    function automatic logic cmd_is_drive(input logic [7:0] code);
        cmd_is_drive = (code == `AXD_CMD_FIX_PLUS) | (code == `AXD_CMD_FIX_MINUS) |
                       (code == `AXD_CMD_CONT_PLUS) | (code == `AXD_CMD_CONT_MINUS);
    endfunction

    function automatic logic cmd_is_minus(input logic [7:0] code);
        cmd_is_minus = (code == `AXD_CMD_FIX_MINUS) | (code == `AXD_CMD_CONT_MINUS);
    endfunction

    axd_enc_if enc ();

    axd_real_pos u_real_pos (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .enc(enc)
    );

    assign enc.phase_a = encoder_phase_a_in;
    assign enc.phase_b = encoder_phase_b_in;
    assign enc.count_up = count_up_input_in;
    assign enc.count_down = count_down_input_in;
    assign enc.mode = count_mode_in ? AXD_UPDN : AXD_QUAD;
    assign real_pos_out = enc.position;

    // host write side
    logic strobe_prev_reg;
    logic [15:0] data_low_word_reg;
    logic [15:0] data_high_word_reg;
    logic [7:0] command_high_byte_reg;
    logic [1:0] busy_cnt_reg;
    logic [1:0] busy_cnt_next;
    logic busy_n_reg;
    logic strobe_rise;
    logic cmd_go;
    logic [7:0] cmd_code;
    logic busy_rise;

    assign strobe_rise = write_strobe_n_in & ~strobe_prev_reg;
    assign cmd_code = data_in[7:0];
    // the low byte carries the command, so it goes last on a byte bus
    assign cmd_go = strobe_rise & (addr_in == `AXD_ADDR_CMD_LOW);
    assign busy_cnt_next = strobe_rise ? `AXD_BUSY_CYCLES :
                           (busy_cnt_reg != 2'h0) ? busy_cnt_reg - 2'h1 : 2'h0;
    assign busy_rise = !busy_n_reg && (busy_cnt_next == 2'h0);
    assign write_busy_n_out = busy_n_reg;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            strobe_prev_reg <= 1'b1;
            busy_cnt_reg <= 2'h0;
            busy_n_reg <= 1'b1;
        end else begin
            strobe_prev_reg <= write_strobe_n_in;
            busy_cnt_reg <= busy_cnt_next;
            busy_n_reg <= (busy_cnt_next == 2'h0);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data_low_word_reg <= `AXD_RESET_WORD;
            data_high_word_reg <= `AXD_RESET_WORD;
            command_high_byte_reg <= 8'h00;
        end else if (strobe_rise) begin
            if (addr_in == `AXD_ADDR_DATA_LOW) begin
                data_low_word_reg <= data_in;
            end
            if (addr_in == `AXD_ADDR_DATA_HIGH) begin
                data_high_word_reg <= data_in;
            end
            if (addr_in == `AXD_ADDR_CMD_HIGH && byte_bus_in) begin
                command_high_byte_reg <= data_in[7:0];
            end else if (addr_in == `AXD_ADDR_CMD_LOW && !byte_bus_in) begin
                command_high_byte_reg <= data_in[15:8];
            end
        end
    end

    // drive sequencer
    axd_state_t state_reg;
    axd_state_t state_next;
    logic pend_reg;
    logic pend_minus_reg;
    logic pend_cont_reg;
    logic minus_reg;
    logic cont_reg;
    logic stop_reg;
    logic [1:0] seq_cnt_reg;
    logic [7:0] width_cnt_reg;
    logic [31:0] remain_reg;
    logic [31:0] done_reg;
    logic drive_reg;
    logic pulse_next;
    logic start_pulse;
    logic high_end;
    logic low_end;
    logic finish;
    logic launch;

    assign launch = busy_rise && pend_reg && (state_reg == AXD_IDLE);
    assign high_end = (state_reg == AXD_HIGH) && (width_cnt_reg == `AXD_PULSE_HIGH - 8'h01);
    assign low_end = (state_reg == AXD_LOW) && (width_cnt_reg == `AXD_PULSE_LOW - 8'h01);
    assign finish = (state_reg == AXD_START && seq_cnt_reg == `AXD_PULSE_DELAY - 2'h1 &&
                     !cont_reg && remain_reg == 32'h0) ||
                    (low_end && (stop_reg || (!cont_reg && remain_reg == 32'h0)));
    assign start_pulse = ((state_reg == AXD_START) && (seq_cnt_reg == `AXD_PULSE_DELAY - 2'h1) && !finish) ||
                         (low_end && !finish);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            AXD_IDLE: begin
                if (launch) begin
                    state_next = AXD_START;
                end
            end
            AXD_START: begin
                if (finish) begin
                    state_next = AXD_IDLE;
                end else if (start_pulse) begin
                    state_next = AXD_HIGH;
                end
            end
            AXD_HIGH: begin
                if (high_end) begin
                    state_next = AXD_LOW;
                end
            end
            AXD_LOW: begin
                if (finish) begin
                    state_next = AXD_IDLE;
                end else if (start_pulse) begin
                    state_next = AXD_HIGH;
                end
            end
            default: begin
                state_next = AXD_IDLE;
            end
        endcase
    end

    assign pulse_next = (state_next == AXD_HIGH);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend_reg <= 1'b0;
            pend_minus_reg <= 1'b0;
            pend_cont_reg <= 1'b0;
            stop_reg <= 1'b0;
        end else begin
            if (cmd_go && cmd_is_drive(cmd_code) && state_reg == AXD_IDLE) begin
                pend_reg <= 1'b1;
                pend_minus_reg <= cmd_is_minus(cmd_code);
                pend_cont_reg <= cmd_code[1];
            end else if (launch) begin
                pend_reg <= 1'b0;
            end
            if (cmd_go && cmd_code == `AXD_CMD_STOP && state_reg != AXD_IDLE) begin
                stop_reg <= 1'b1;
            end else if (finish) begin
                stop_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= AXD_IDLE;
            seq_cnt_reg <= 2'h0;
            width_cnt_reg <= 8'h00;
            minus_reg <= 1'b0;
            cont_reg <= 1'b0;
            remain_reg <= 32'h0;
            done_reg <= 32'h0;
        end else begin
            state_reg <= state_next;
            seq_cnt_reg <= launch ? 2'h0 : seq_cnt_reg + {1'b0, state_reg == AXD_START};
            width_cnt_reg <= (start_pulse || high_end) ? 8'h00 : width_cnt_reg + 8'h01;
            if (launch) begin
                minus_reg <= pend_minus_reg;
                cont_reg <= pend_cont_reg;
                remain_reg <= {data_high_word_reg, data_low_word_reg};
                done_reg <= 32'h0;
            end else if (start_pulse) begin
                remain_reg <= cont_reg ? remain_reg : remain_reg - 32'h1;
                done_reg <= done_reg + 32'h1;
            end
        end
    end

    // axis outputs, all registered on the rising edge
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            drive_reg <= 1'b0;
            direction_out <= 1'b0;
            plus_pulse_out <= 1'b0;
            minus_pulse_out <= 1'b0;
            single_pulse_out <= 1'b0;
            accel_phase_out <= 1'b0;
            decel_phase_out <= 1'b0;
        end else begin
            if (launch) begin
                drive_reg <= 1'b1;
            end else if (finish) begin
                drive_reg <= 1'b0;
            end
            if (state_reg == AXD_START && seq_cnt_reg == `AXD_DIR_DELAY - 2'h1) begin
                direction_out <= ~minus_reg;
            end
            plus_pulse_out <= pulse_next & ~pulse_dir_mode_in & ~minus_reg;
            minus_pulse_out <= pulse_next & ~pulse_dir_mode_in & minus_reg;
            single_pulse_out <= pulse_next & pulse_dir_mode_in;
            if (finish) begin
                accel_phase_out <= 1'b0;
                decel_phase_out <= 1'b0;
            end else if (start_pulse) begin
                accel_phase_out <= done_reg < `AXD_RAMP_PULSES;
                decel_phase_out <= !cont_reg && remain_reg <= `AXD_RAMP_PULSES;
            end
        end
    end

    assign drive_active_out = drive_reg;
endmodule

`default_nettype wire

//--- src/axd_map.svh
`ifndef AXD_MAP_SVH
`define AXD_MAP_SVH

`define AXD_ADDR_CMD_LOW 3'h0
`define AXD_ADDR_CMD_HIGH 3'h1
`define AXD_ADDR_DATA_LOW 3'h6
`define AXD_ADDR_DATA_HIGH 3'h7

`define AXD_CMD_FIX_PLUS 8'h20
`define AXD_CMD_FIX_MINUS 8'h21
`define AXD_CMD_CONT_PLUS 8'h22
`define AXD_CMD_CONT_MINUS 8'h23
`define AXD_CMD_STOP 8'h27

`define AXD_BUSY_CYCLES 2'h2
`define AXD_DIR_DELAY 2'h1
`define AXD_PULSE_DELAY 2'h3

`define AXD_PULSE_HIGH 8'h04
`define AXD_PULSE_LOW 8'h04
`define AXD_RAMP_PULSES 32'h0000_0010

`define AXD_RESET_WORD 16'h0000
`define AXD_RESET_POS 32'h0000_0000

`endif

//--- src/axd_pkg.sv
package axd_pkg;

    typedef enum logic [3:0] {
        AXD_IDLE = 4'h1,
        AXD_START = 4'h2,
        AXD_HIGH = 4'h4,
        AXD_LOW = 4'h8
    } axd_state_t;

    typedef enum logic {
        AXD_QUAD = 1'h0,
        AXD_UPDN = 1'h1
    } axd_in_mode_t;

endpackage

//--- src/axd_enc_if.sv
`timescale 1ns/100ps
`default_nettype none

interface axd_enc_if;
    import axd_pkg::*;
    logic phase_a;
    logic phase_b;
    logic count_up;
    logic count_down;
    axd_in_mode_t mode;
    logic [31:0] position;

    modport src (output phase_a, output phase_b, output count_up, output count_down, output mode, input position);
    modport cnt (input phase_a, input phase_b, input count_up, input count_down, input mode, output position);
endinterface

`default_nettype wire

//--- src/axd_real_pos.sv
`timescale 1ns/100ps
`default_nettype none
`include "axd_map.svh"

module axd_real_pos
    import axd_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    axd_enc_if.cnt enc
);
    logic a_prev_reg;
    logic b_prev_reg;
    logic up_prev_reg;
    logic down_prev_reg;
    logic [31:0] pos_reg;
    logic [3:0] quad_code;
    logic quad_up;
    logic quad_down;
    logic step_up;
    logic step_down;

    // a leads b counts up: 00 -> 10 -> 11 -> 01 -> 00
    assign quad_code = {a_prev_reg, b_prev_reg, enc.phase_a, enc.phase_b};
    assign quad_up = (quad_code == 4'h2) | (quad_code == 4'hB) | (quad_code == 4'hD) | (quad_code == 4'h4);
    assign quad_down = (quad_code == 4'h1) | (quad_code == 4'h7) | (quad_code == 4'hE) | (quad_code == 4'h8);
    assign step_up = (enc.mode == AXD_QUAD) ? quad_up : (enc.count_up & ~up_prev_reg);
    assign step_down = (enc.mode == AXD_QUAD) ? quad_down : (enc.count_down & ~down_prev_reg);
    assign enc.position = pos_reg;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            a_prev_reg <= 1'b0;
            b_prev_reg <= 1'b0;
            up_prev_reg <= 1'b0;
            down_prev_reg <= 1'b0;
        end else begin
            a_prev_reg <= enc.phase_a;
            b_prev_reg <= enc.phase_b;
            up_prev_reg <= enc.count_up;
            down_prev_reg <= enc.count_down;
        end
    end

    // counter moves one edge after the input change
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pos_reg <= `AXD_RESET_POS;
        end else if (step_up && !step_down) begin
            pos_reg <= pos_reg + 32'h0000_0001;
        end else if (step_down && !step_up) begin
            pos_reg <= pos_reg - 32'h0000_0001;
        end
    end
endmodule

`default_nettype wire

//--- sim/axd_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module axd_checker (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic write_strobe_n_in,
    input wire logic count_mode_in,
    input wire logic encoder_phase_a_in,
    input wire logic encoder_phase_b_in,
    input wire logic count_up_input_in,
    input wire logic count_down_input_in,
    input wire logic write_busy_n_out,
    input wire logic plus_pulse_out,
    input wire logic minus_pulse_out,
    input wire logic single_pulse_out,
    input wire logic direction_out,
    input wire logic drive_active_out,
    input wire logic accel_phase_out,
    input wire logic decel_phase_out,
    input wire logic [31:0] real_pos_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    wire logic any_p = plus_pulse_out | minus_pulse_out | single_pulse_out;
    wire logic drv = drive_active_out;
    wire logic ph = accel_phase_out | decel_phase_out;
    wire logic quad = !count_mode_in;
    busy_max_a: assert property (!write_busy_n_out [*2] |=> write_busy_n_out) else $error("busy too long");
    busy_cause_a: assert property ($fell(write_busy_n_out) |->
        $past(write_strobe_n_in) && !$past(write_strobe_n_in, 2)) else $error("busy without strobe");
    drive_start_a: assert property ($rose(drv) |-> $rose(write_busy_n_out)) else $error("drive start");
    pulse_start_a: assert property ($rose(drv) |-> !any_p [*3] ##1 (any_p || !drv)) else $error("pulse start");
    phase_start_a: assert property ($rose(drv) |-> !ph [*3]) else $error("phase early");
    phase_idle_a: assert property (!drv |-> !ph) else $error("phase after drive");
    dir_hold_a: assert property (drv && $past(drv, 2) |-> $stable(direction_out)) else $error("dir moved");
    dir_match_a: assert property (any_p && !single_pulse_out |-> direction_out == plus_pulse_out)
        else $error("dir mismatch");
    pulse_drive_a: assert property (any_p |-> drv) else $error("pulse while idle");
    quad_track_a: assert property (quad && ($changed(encoder_phase_a_in) || $changed(encoder_phase_b_in))
        |-> ##[1:4] $changed(real_pos_out)) else $error("quad count late");
    updn_track_a: assert property (count_mode_in && ($rose(count_up_input_in) || $rose(count_down_input_in))
        |-> ##[1:4] $changed(real_pos_out)) else $error("updn count late");
    cover property ($rose(drv));
    cover property ($rose(decel_phase_out));
    cover property (count_mode_in && $changed(real_pos_out));
endmodule
bind axd_axis axd_checker u_chk (.clk_in, .rst_n_in, .write_strobe_n_in, .count_mode_in, .encoder_phase_a_in,
    .encoder_phase_b_in, .count_up_input_in, .count_down_input_in, .write_busy_n_out, .plus_pulse_out,
    .minus_pulse_out, .single_pulse_out, .direction_out, .drive_active_out, .accel_phase_out, .decel_phase_out,
    .real_pos_out);
`default_nettype wire

//--- sim/axd_enc_model.sv
`timescale 1ns/100ps
`default_nettype none
module axd_enc_model (
    input wire logic clk_in,
    input wire logic mode_in,
    input wire logic fwd_in,
    input wire logic rev_in,
    output logic phase_a_out,
    output logic phase_b_out,
    output var logic up_out,
    output var logic down_out
);
    logic [1:0] idx_reg = 2'h0;
    initial begin
        up_out = 1'b0;
        down_out = 1'b0;
    end
    // gray steps, phase a leads phase b going forward
    assign phase_a_out = idx_reg[1] ^ idx_reg[0];
    assign phase_b_out = idx_reg[1];
    always @(posedge clk_in) begin
        if (!mode_in) begin
            idx_reg <= idx_reg + {rev_in, fwd_in | rev_in};
        end
        up_out <= mode_in & fwd_in;
        down_out <= mode_in & rev_in;
    end
endmodule
`default_nettype wire

//--- sim/tb_axis_drive_start_timing.sv
`timescale 1ns/100ps
`default_nettype none
`include "axd_map.svh"
module tb_axis_drive_start_timing;
    logic clk_in = 1'b0, rst_n_in = 1'b0, write_strobe_n_in = 1'b1, byte_bus_in = 1'b0;
    logic pulse_dir_mode_in = 1'b0, count_mode_in = 1'b0, fwd = 1'b0, rev = 1'b0;
    logic [2:0] addr_in = 3'h0;
    logic [15:0] data_in = 16'h0000;
    logic [31:0] pos_exp = 32'h0000_0000;
    wire logic encoder_phase_a_in, encoder_phase_b_in, count_up_input_in, count_down_input_in;
    wire logic write_busy_n_out, plus_pulse_out, minus_pulse_out, single_pulse_out, direction_out;
    wire logic drive_active_out, accel_phase_out, decel_phase_out;
    wire logic [31:0] real_pos_out;
    int n_errors = 0, check_count = 0, cyc = 0;
    always #2 clk_in = ~clk_in;
    axd_axis u_dut (.clk_in, .rst_n_in, .write_strobe_n_in, .addr_in, .data_in, .byte_bus_in, .pulse_dir_mode_in,
        .count_mode_in, .encoder_phase_a_in, .encoder_phase_b_in, .count_up_input_in, .count_down_input_in,
        .write_busy_n_out, .plus_pulse_out, .minus_pulse_out, .single_pulse_out, .direction_out, .drive_active_out,
        .accel_phase_out, .decel_phase_out, .real_pos_out);
    axd_enc_model u_enc (.clk_in, .mode_in(count_mode_in), .fwd_in(fwd), .rev_in(rev),
        .phase_a_out(encoder_phase_a_in), .phase_b_out(encoder_phase_b_in),
        .up_out(count_up_input_in), .down_out(count_down_input_in));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("comparisons=%0d mismatches=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // inputs move and outputs are read half a nanosecond after the edge
    task tick;
        @(posedge clk_in);
        #0.5;
    endtask
    task host_write(input logic [2:0] a, input logic [15:0] d);
        int low;
        low = 0;
        tick;
        write_strobe_n_in = 1'b0;
        addr_in = a;
        data_in = d;
        tick;
        write_strobe_n_in = 1'b1;
        tick;
        while (write_busy_n_out === 1'b0 && low < 6) begin
            low++;
            tick;
        end
        check(32'(low), 32'h2);
    endtask
    task run_drive(input string nm, input logic [7:0] cmd, input logic [15:0] hi, lo, input logic single, bytew,
        input int stop_at, exp_n, input logic exp_dec);
        logic sel, prev, seen_dec;
        int n, other, k, sd;
        pulse_dir_mode_in = single;
        byte_bus_in = bytew;
        host_write(`AXD_ADDR_DATA_HIGH, hi);
        host_write(`AXD_ADDR_DATA_LOW, lo);
        if (bytew) begin
            host_write(`AXD_ADDR_CMD_HIGH, 16'h0000);
        end
        host_write(`AXD_ADDR_CMD_LOW, {8'h00, cmd});
        check(drive_active_out, 1'b1);
        n = 0;
        other = 0;
        prev = 1'b0;
        seen_dec = 1'b0;
        sd = 0;
        for (k = 1; k < 600 && drive_active_out === 1'b1; k++) begin
            tick;
            if (sd == 1) begin
                write_strobe_n_in = 1'b1;
                sd = 2;
            end
            sel = single ? single_pulse_out : (cmd[0] ? minus_pulse_out : plus_pulse_out);
            if ((plus_pulse_out | minus_pulse_out | single_pulse_out) && !sel) other++;
            if (k == 1) check(direction_out, !cmd[0]);
            if (k == 2) check(sel, 1'b0);
            if (k == 3) check(sel, exp_n != 0);
            if (k == 3 && !cmd[1] && exp_n != 0) check(accel_phase_out, 1'b1);
            if (sel && !prev) n++;
            prev = sel;
            seen_dec |= decel_phase_out;
            if (stop_at > 0 && n == stop_at && sd == 0) begin
                write_strobe_n_in = 1'b0;
                data_in = {8'h00, `AXD_CMD_STOP};
                addr_in = `AXD_ADDR_CMD_LOW;
                sd = 1;
            end
        end
        check(32'(k), 1 + `AXD_PULSE_DELAY + exp_n * (`AXD_PULSE_HIGH + `AXD_PULSE_LOW));
        check({accel_phase_out, decel_phase_out}, 2'h0);
        check(32'(n), 32'(exp_n));
        check(32'(other), 32'h0);
        if (!cmd[1]) check(seen_dec, exp_dec);
        $display("test %s done", nm);
    endtask
    task enc_steps(input string nm, input logic mode, input int nf, nr);
        count_mode_in = mode;
        tick;
        for (int i = 0; i < nf + nr; i++) begin
            fwd = i < nf;
            rev = i >= nf;
            tick;
            fwd = 1'b0;
            rev = 1'b0;
            pos_exp = (i < nf) ? pos_exp + 32'h1 : pos_exp - 32'h1;
            repeat (4) tick;
            check(real_pos_out, pos_exp);
        end
        $display("test %s done", nm);
    endtask
    task stop_idle;
        host_write(`AXD_ADDR_CMD_LOW, {8'h00, `AXD_CMD_STOP});
        repeat (4) tick;
        check(drive_active_out, 1'b0);
        check(plus_pulse_out | minus_pulse_out | single_pulse_out, 1'b0);
        $display("test stop_idle done");
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            wrap_up;
        end
    end
    initial begin
        repeat (12) @(posedge clk_in);
        #0.5;
        rst_n_in = 1'b1;
        run_drive("fix_plus", `AXD_CMD_FIX_PLUS, 16'h0000, 16'h0003, 1'b0, 1'b0, 0, 3, 1'b1);
        run_drive("fix_minus_single", `AXD_CMD_FIX_MINUS, 16'h0000, 16'h0014, 1'b1, 1'b1, 0, 20, 1'b1);
        run_drive("fix_high_word", `AXD_CMD_FIX_PLUS, 16'h0001, 16'h0000, 1'b0, 1'b0, 3, 3, 1'b0);
        run_drive("fix_zero", `AXD_CMD_FIX_MINUS, 16'h0000, 16'h0000, 1'b0, 1'b0, 0, 0, 1'b0);
        run_drive("cont_plus", `AXD_CMD_CONT_PLUS, 16'h0000, 16'h0000, 1'b0, 1'b0, 2, 2, 1'b0);
        run_drive("cont_minus", `AXD_CMD_CONT_MINUS, 16'h0000, 16'h0000, 1'b1, 1'b0, 1, 1, 1'b0);
        stop_idle;
        enc_steps("quad", 1'b0, 3, 1);
        enc_steps("updown", 1'b1, 2, 3);
        wrap_up;
    end
endmodule
`default_nettype wire
